// File: core/banked_regfile_pkg.sv
`default_nettype none
package banked_regfile_pkg;

   // ---------------------------------------------------------------
   // Sizes of the register file.
   // ---------------------------------------------------------------
   localparam int unsigned DATA_W = 32;
   localparam int unsigned PHYS_COUNT = 31;
   localparam int unsigned SAVED_COUNT = 5;

   // Visible register indices with a fixed role.
   localparam logic [3:0] IDX_SHARED_HI = 4'h7;
   localparam logic [3:0] IDX_FIQ_HI = 4'hC;
   localparam logic [3:0] IDX_STACK = 4'hD;
   localparam logic [3:0] IDX_LINK = 4'hE;
   localparam logic [3:0] IDX_PC = 4'hF;

   // ---------------------------------------------------------------
   // Physical slots behind the visible indices.
   // ---------------------------------------------------------------
   localparam logic [4:0] PHYS_FIQ_BASE = 5'h0D;  // Private copies of 8..12 start here.
   localparam logic [4:0] PHYS_USER_SP = 5'h12;   // Each bank is a stack slot plus a link slot.
   localparam logic [4:0] PHYS_SVC_SP = 5'h14;
   localparam logic [4:0] PHYS_ABT_SP = 5'h16;
   localparam logic [4:0] PHYS_UND_SP = 5'h18;
   localparam logic [4:0] PHYS_IRQ_SP = 5'h1A;
   localparam logic [4:0] PHYS_FIQ_SP = 5'h1C;
   localparam logic [4:0] PHYS_PC = 5'h1E;

   // Saved status slots, one per exception mode.
   localparam logic [2:0] SAVED_SVC = 3'h0;
   localparam logic [2:0] SAVED_ABT = 3'h1;
   localparam logic [2:0] SAVED_UND = 3'h2;
   localparam logic [2:0] SAVED_IRQ = 3'h3;
   localparam logic [2:0] SAVED_FIQ = 3'h4;

   // ---------------------------------------------------------------
   // Processor mode codes held in the low status bits.
   // ---------------------------------------------------------------
   localparam logic [4:0] MODE_USER = 5'h10;
   localparam logic [4:0] MODE_FIQ = 5'h11;
   localparam logic [4:0] MODE_IRQ = 5'h12;
   localparam logic [4:0] MODE_SVC = 5'h13;
   localparam logic [4:0] MODE_ABT = 5'h17;
   localparam logic [4:0] MODE_UND = 5'h1B;
   localparam logic [4:0] MODE_SYS = 5'h1F;

   // ---------------------------------------------------------------
   // Status word layout and reset value.
   // ---------------------------------------------------------------
   localparam int unsigned MODE_MSB = 4;
   localparam int unsigned STATE_BIT = 5;      // Set while in the compact instruction state.
   localparam int unsigned FIQ_DIS_BIT = 6;
   localparam int unsigned IRQ_DIS_BIT = 7;
   localparam int unsigned FLAGS_LSB = 28;     // Negative, zero, carry, overflow.
   localparam logic [31:0] STATUS_RESET = 32'h0000_00D3;

   // Instruction widths per instruction state.
   localparam logic [5:0] INSTR_W_STD = 6'h20;
   localparam logic [5:0] INSTR_W_COMPACT = 6'h10;

   // Byte and half-word lane masks.
   localparam logic [31:0] BYTE_MASK = 32'h0000_00FF;
   localparam logic [31:0] HALF_MASK = 32'h0000_FFFF;
   localparam int unsigned BYTE_SIGN = 7;
   localparam int unsigned HALF_SIGN = 15;

   // Data size of a register write.
   typedef enum logic [1:0] {
      SIZE_BYTE = 2'h0,
      SIZE_HALF = 2'h1,
      SIZE_WORD = 2'h2
   } data_size_t;

   // Register write from the datapath.
   typedef struct packed {
      logic valid;
      logic [3:0] idx;
      data_size_t size;
      logic sign;
      logic [31:0] data;
   } reg_write_t;

   // Exception entry request.
   typedef struct packed {
      logic valid;
      logic [4:0] mode;
      logic [31:0] ret_addr;
   } exc_req_t;

endpackage
`default_nettype wire

// File: core/banked_mode_register_file.sv
// Functional notes
// - Seven modes select the visible registers.
// - Thirty-one physical 32-bit general registers.
// - Sixteen visible; rest are exception alternates.
// - Index 15 is the program counter.
// - Subroutine call writes return into index 14.
// - Indices 0 to 7 shared by all modes.
// - Indices 8 to 14 banked by mode.
// - Mode changes by software or exception entry.
// - Every mode except user is privileged.
// - Instructions 32 bits standard, 16 compact.
// - Byte, half-word and word data supported.
// - Fast interrupt mode owns private 8 to 12.
// - Each exception mode owns private index 13.
// - Five exception modes each own saved status.
// - Exception entry saves link and status.
`timescale 1ns/1ps
`default_nettype none
module banked_mode_register_file
   import banked_regfile_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic [3:0] rd_idx_a_i,
   input wire logic [3:0] rd_idx_b_i,
   input wire reg_write_t wr_i,
   input wire logic call_i,
   input wire logic [31:0] call_addr_i,
   input wire logic mode_wr_i,
   input wire logic [31:0] mode_wr_status_i,
   input wire exc_req_t exc_i,
   input wire logic exc_ret_i,
   output logic [31:0] rd_data_a_o,
   output logic [31:0] rd_data_b_o,
   output logic [31:0] pc_o,
   output logic [31:0] current_status_o,
   output logic [31:0] saved_status_o,
   output logic saved_valid_o,
   output logic privileged_o,
   output logic [5:0] instr_width_o,
   output logic mode_err_o
);

   // ---------------------------------------------------------------
   // Mapping helpers.
   // ---------------------------------------------------------------

   // Turns a mode and a visible index into a physical slot.
   function automatic logic [4:0] phys_idx(input logic [4:0] mode, input logic [3:0] idx);
      logic [4:0] sp;
      sp = PHYS_USER_SP;
      case (mode)
         MODE_SVC: sp = PHYS_SVC_SP;
         MODE_ABT: sp = PHYS_ABT_SP;
         MODE_UND: sp = PHYS_UND_SP;
         MODE_IRQ: sp = PHYS_IRQ_SP;
         MODE_FIQ: sp = PHYS_FIQ_SP;
         default: sp = PHYS_USER_SP;   // User and system share one set.
      endcase
      if (idx == IDX_PC)
      begin
         phys_idx = PHYS_PC;
      end
      else if (idx <= IDX_SHARED_HI)
      begin
         phys_idx = {1'b0, idx};
      end
      else if (idx <= IDX_FIQ_HI)
      begin
         // Only the fast interrupt mode swaps out 8 to 12.
         phys_idx = (mode == MODE_FIQ) ? PHYS_FIQ_BASE + 5'(idx - 4'h8) : {1'b0, idx};
      end
      else
      begin
         phys_idx = sp + 5'(idx - IDX_STACK);
      end
   endfunction

   // Saved status slot of a mode; valid is low for user and system.
   function automatic logic [3:0] saved_slot(input logic [4:0] mode);
      case (mode)
         MODE_SVC: saved_slot = {1'b1, SAVED_SVC};
         MODE_ABT: saved_slot = {1'b1, SAVED_ABT};
         MODE_UND: saved_slot = {1'b1, SAVED_UND};
         MODE_IRQ: saved_slot = {1'b1, SAVED_IRQ};
         MODE_FIQ: saved_slot = {1'b1, SAVED_FIQ};
         default: saved_slot = 4'h0;
      endcase
   endfunction

   // True for the seven legal mode codes.
   function automatic logic mode_ok(input logic [4:0] mode);
      mode_ok = (mode == MODE_USER) || (mode == MODE_SYS) || (saved_slot(mode) != 4'h0);
   endfunction

   // Extends byte and half-word data to a full register.
   function automatic logic [31:0] extend(input data_size_t size, input logic sign,
                                          input logic [31:0] data);
      case (size)
         SIZE_BYTE: extend = (data & BYTE_MASK) |
                             ((sign && data[BYTE_SIGN]) ? ~BYTE_MASK : 32'h0000_0000);
         SIZE_HALF: extend = (data & HALF_MASK) |
                             ((sign && data[HALF_SIGN]) ? ~HALF_MASK : 32'h0000_0000);
         default: extend = data;
      endcase
   endfunction

   // ---------------------------------------------------------------
   // State.
   // ---------------------------------------------------------------
   logic [31:0] phys_reg [PHYS_COUNT];    // All physical registers.
   logic [31:0] phys_next [PHYS_COUNT];
   logic [31:0] saved_reg [SAVED_COUNT];  // Saved status per exception mode.
   logic [31:0] saved_next [SAVED_COUNT];
   logic [31:0] status_reg;               // Current status word.
   logic [31:0] status_next;
   logic [31:0] rd_a_reg, rd_a_next;      // Registered read results.
   logic [31:0] rd_b_reg, rd_b_next;
   logic [31:0] saved_out_reg, saved_out_next;
   logic saved_valid_reg, saved_valid_next;
   logic priv_reg, priv_next;
   logic [5:0] width_reg, width_next;
   logic mode_err_reg, mode_err_next;
   logic [4:0] cur_mode;                  // Mode in force this cycle.
   logic [3:0] cur_saved;
   logic [3:0] exc_saved;
   logic [3:0] new_saved;                 // Saved slot of the mode after the edge.

   assign cur_mode = status_reg[MODE_MSB:0];
   assign cur_saved = saved_slot(cur_mode);
   assign exc_saved = saved_slot(exc_i.mode);

   // ---------------------------------------------------------------
   // Next-state logic.
   // ---------------------------------------------------------------
   // Later updates win: exception entry beats a call, a call beats a
   // plain write, so a plain write in the same cycle cannot overwrite a return address.
   always_comb
   begin
      phys_next = phys_reg;
      saved_next = saved_reg;
      status_next = status_reg;
      mode_err_next = 1'b0;
      // Plain register write through the current mode's view.
      if (wr_i.valid)
      begin
         phys_next[phys_idx(cur_mode, wr_i.idx)] = extend(wr_i.size, wr_i.sign, wr_i.data);
      end
      // Subroutine call leaves its return address in index 14.
      if (call_i)
      begin
         phys_next[phys_idx(cur_mode, IDX_LINK)] = call_addr_i;
      end
      // Software mode write; user mode may only touch the flags.
      if (mode_wr_i)
      begin
         if (cur_mode == MODE_USER)
         begin
            status_next[31:FLAGS_LSB] = mode_wr_status_i[31:FLAGS_LSB];
         end
         else if (mode_ok(mode_wr_status_i[MODE_MSB:0]))
         begin
            status_next = mode_wr_status_i;
         end
         else
         begin
            // An illegal mode code is refused and flagged for one cycle.
            mode_err_next = 1'b1;
         end
      end
      // Return from exception restores the saved status, if any.
      if (exc_ret_i && cur_saved[3])
      begin
         status_next = saved_reg[cur_saved[2:0]];
      end
      // Exception entry saves link and status into the target bank.
      if (exc_i.valid && exc_saved[3])
      begin
         phys_next[phys_idx(exc_i.mode, IDX_LINK)] = exc_i.ret_addr;
         saved_next[exc_saved[2:0]] = status_reg;
         status_next = status_reg;
         status_next[MODE_MSB:0] = exc_i.mode;
         status_next[STATE_BIT] = 1'b0;
         status_next[IRQ_DIS_BIT] = 1'b1;
         if (exc_i.mode == MODE_FIQ)
         begin
            status_next[FIQ_DIS_BIT] = 1'b1;
         end
      end
      // Reads show the contents before this cycle's writes.
      rd_a_next = phys_reg[phys_idx(cur_mode, rd_idx_a_i)];
      rd_b_next = phys_reg[phys_idx(cur_mode, rd_idx_b_i)];
      // Status views track the mode that is in force after the edge.
      new_saved = saved_slot(status_next[MODE_MSB:0]);
      saved_valid_next = new_saved[3];
      saved_out_next = new_saved[3] ? saved_next[new_saved[2:0]] : 32'h0000_0000;
      priv_next = (status_next[MODE_MSB:0] != MODE_USER);
      width_next = status_next[STATE_BIT] ? INSTR_W_COMPACT : INSTR_W_STD;
   end

   // ---------------------------------------------------------------
   // Registers.
   // ---------------------------------------------------------------
   // Register contents are cleared so that simulation starts defined.
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         phys_reg <= '{default: 32'h0000_0000};
         saved_reg <= '{default: 32'h0000_0000};
         status_reg <= STATUS_RESET;
         rd_a_reg <= 32'h0000_0000;
         rd_b_reg <= 32'h0000_0000;
         saved_out_reg <= 32'h0000_0000;
         saved_valid_reg <= 1'b1;
         priv_reg <= 1'b1;
         width_reg <= INSTR_W_STD;
         mode_err_reg <= 1'b0;
      end
      else
      begin
         phys_reg <= phys_next;
         saved_reg <= saved_next;
         status_reg <= status_next;
         rd_a_reg <= rd_a_next;
         rd_b_reg <= rd_b_next;
         saved_out_reg <= saved_out_next;
         saved_valid_reg <= saved_valid_next;
         priv_reg <= priv_next;
         width_reg <= width_next;
         mode_err_reg <= mode_err_next;
      end
   end

   assign rd_data_a_o = rd_a_reg;
   assign rd_data_b_o = rd_b_reg;
   assign pc_o = phys_reg[PHYS_PC];
   assign current_status_o = status_reg;
   assign saved_status_o = saved_out_reg;
   assign saved_valid_o = saved_valid_reg;
   assign privileged_o = priv_reg;
   assign instr_width_o = width_reg;
   assign mode_err_o = mode_err_reg;

   // ---------------------------------------------------------------
   // Checks.
   // ---------------------------------------------------------------
   // Helper views so that each check samples plain signals.
   logic [4:0] exc_link_slot, wr_slot, call_slot, rd_a_slot;
   logic [31:0] rd_a_expect;
   assign exc_link_slot = phys_idx(exc_i.mode, IDX_LINK);
   assign wr_slot = phys_idx(cur_mode, wr_i.idx);
   assign call_slot = phys_idx(cur_mode, IDX_LINK);
   assign rd_a_slot = phys_idx(cur_mode, rd_idx_a_i);
   assign rd_a_expect = phys_reg[rd_a_slot];
   // Value of the shared slot behind a write index, before the write lands.
   logic [31:0] fiq_shared_val;
   assign fiq_shared_val = phys_reg[wr_i.idx];

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);

   a_exc_link_save: assert property (exc_i.valid && exc_saved[3] |=>
      phys_reg[$past(exc_link_slot)] == $past(exc_i.ret_addr) &&
      saved_status_o == $past(status_reg))
      else $error("Exception entry did not save link and status.");
   a_exc_mode_entry: assert property (exc_i.valid && exc_saved[3] |=>
      current_status_o[MODE_MSB:0] == $past(exc_i.mode) && privileged_o)
      else $error("Exception entry did not switch mode.");
   a_user_no_saved: assert property ((cur_mode == MODE_USER || cur_mode == MODE_SYS)
      |-> !saved_valid_o && saved_status_o == 32'h0000_0000)
      else $error("User or system mode shows a saved status.");
   a_privileged_flag: assert property (privileged_o == (cur_mode != MODE_USER))
      else $error("Privileged flag disagrees with mode.");
   a_pc_write: assert property (wr_i.valid && wr_i.idx == IDX_PC && wr_i.size == SIZE_WORD
      |=> pc_o == $past(wr_i.data))
      else $error("Write to index 15 did not reach the program counter.");
   a_call_link: assert property (call_i && !exc_i.valid |=>
      phys_reg[$past(call_slot)] == $past(call_addr_i))
      else $error("Call did not leave its return address.");
   a_fiq_private: assert property (cur_mode == MODE_FIQ && wr_i.valid &&
      wr_i.idx >= 4'h8 && wr_i.idx <= IDX_FIQ_HI |=>
      phys_reg[$past(wr_i.idx)] == $past(fiq_shared_val))
      else $error("Fast interrupt write reached a shared register.");
   a_width_state: assert property (instr_width_o ==
      (current_status_o[STATE_BIT] ? INSTR_W_COMPACT : INSTR_W_STD))
      else $error("Instruction width disagrees with state bit.");
   a_read_view: assert property (##1 rd_data_a_o == $past(rd_a_expect))
      else $error("Read did not return the mode view.");

   c_exc_entry: cover property (exc_i.valid && exc_saved[3]);
   c_fiq_entry: cover property (exc_i.valid && exc_i.mode == MODE_FIQ ##2 wr_i.valid);
   c_exc_return: cover property (exc_ret_i && cur_saved[3]);
   c_bad_mode: cover property (mode_err_o);

endmodule
`default_nettype wire

// File: testbench/datapath_model.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Datapath stand-in: issues one request per call at falling edges.
// ---------------------------------------------------------------
module datapath_model
   import banked_regfile_pkg::*;
(
   input wire logic clk_i,
   input wire logic [31:0] rd_a_i,
   input wire logic [31:0] rd_b_i,
   output logic [3:0] idx_a_o,
   output logic [3:0] idx_b_o,
   output reg_write_t wr_o,
   output logic call_o,
   output logic [31:0] call_addr_o,
   output logic mode_wr_o,
   output logic [31:0] status_o,
   output exc_req_t exc_o,
   output logic ret_o
);
   // Idle values at time zero.
   initial
   begin
      idx_a_o = 4'h0;
      idx_b_o = 4'h0;
      wr_o = '0;
      call_o = 1'b0;
      call_addr_o = 32'h0;
      mode_wr_o = 1'b0;
      status_o = 32'h0;
      exc_o = '0;
      ret_o = 1'b0;
   end

   // Released data lines show the inverse so stale values never match.
   task automatic wr(input logic [3:0] i, input data_size_t s, input logic g,
                     input logic [31:0] d);
      @(negedge clk_i);
      wr_o = '{1'b1, i, s, g, d};
      @(negedge clk_i);
      wr_o.valid = 1'b0;
      wr_o.data = ~d;
   endtask

   // Return addresses handed in are driven unchanged for one cycle.
   task automatic call(input logic [31:0] a);
      @(negedge clk_i);
      call_o = 1'b1;
      call_addr_o = a;
      @(negedge clk_i);
      call_o = 1'b0;
      call_addr_o = ~a;
   endtask

   // Software status write.
   task automatic mode(input logic [31:0] s);
      @(negedge clk_i);
      mode_wr_o = 1'b1;
      status_o = s;
      @(negedge clk_i);
      mode_wr_o = 1'b0;
      status_o = ~s;
   endtask

   // Exception entry with the address to come back to.
   task automatic exc(input logic [4:0] m, input logic [31:0] a);
      @(negedge clk_i);
      exc_o = '{1'b1, m, a};
      @(negedge clk_i);
      exc_o.valid = 1'b0;
      exc_o.ret_addr = ~a;
   endtask

   // Return from exception.
   task automatic ret();
      @(negedge clk_i);
      ret_o = 1'b1;
      @(negedge clk_i);
      ret_o = 1'b0;
   endtask

   // Both read ports; results land one edge after the index.
   task automatic rd(input logic [3:0] ia, input logic [3:0] ib,
                     output logic [31:0] a, output logic [31:0] b);
      @(negedge clk_i);
      idx_a_o = ia;
      idx_b_o = ib;
      @(negedge clk_i);
      a = rd_a_i;
      b = rd_b_i;
   endtask
endmodule
`default_nettype wire

// File: testbench/banked_mode_register_file_tb.sv
`timescale 1ns/1ps
`default_nettype none
module banked_mode_register_file_tb
   import banked_regfile_pkg::*;
();
   // ---------------------------------------------------------------
   // Signals and counters.
   // ---------------------------------------------------------------
   logic core_clk_i, sys_rst_i, call, mode_wr, ret, sav_v, priv, merr;
   logic [3:0] ia, ib;
   logic [5:0] iw;
   logic [31:0] call_a, mst, rda, rdb, pc, cur, sav, ra, rb;
   reg_write_t wr;
   exc_req_t exc;
   int mismatches = 0;
   int checks = 0;
   logic [4:0] md [6] = '{MODE_SVC, MODE_ABT, MODE_UND, MODE_IRQ, MODE_FIQ, MODE_SYS};
   logic [31:0] ev [5] = '{32'hFFFFFF80, 32'h80, 32'hFFFF8780, 32'h8780, 32'h12348780};

   banked_mode_register_file u_dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
      .rd_idx_a_i(ia), .rd_idx_b_i(ib), .wr_i(wr), .call_i(call), .call_addr_i(call_a),
      .mode_wr_i(mode_wr), .mode_wr_status_i(mst), .exc_i(exc), .exc_ret_i(ret),
      .rd_data_a_o(rda), .rd_data_b_o(rdb), .pc_o(pc), .current_status_o(cur),
      .saved_status_o(sav), .saved_valid_o(sav_v), .privileged_o(priv),
      .instr_width_o(iw), .mode_err_o(merr));
   datapath_model u_dp (.clk_i(core_clk_i), .rd_a_i(rda), .rd_b_i(rdb), .idx_a_o(ia),
      .idx_b_o(ib), .wr_o(wr), .call_o(call), .call_addr_o(call_a), .mode_wr_o(mode_wr),
      .status_o(mst), .exc_o(exc), .ret_o(ret));

   // Free-running core clock at 10 MHz.
   initial
   begin
      core_clk_i = 1'b0;
      forever #50 core_clk_i = ~core_clk_i;
   end

   // Compares one value, counting every call.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Scenarios.
   // ---------------------------------------------------------------
   task automatic t_reset();
      check(cur, STATUS_RESET);
      check({31'h0, priv}, 32'h1);
      check({31'h0, sav_v}, 32'h1);
      check({26'h0, iw}, 32'h20);
      check(pc, 32'h0);
      $display("test reset done");
   endtask

   // Fast interrupt entry swaps in a private 8..12 but keeps 0..7.
   task automatic t_fiq();
      for (int i = 0; i < 13; i++)
         u_dp.wr(4'(i), SIZE_WORD, 1'b0, 32'hB0 + i);
      u_dp.exc(MODE_FIQ, 32'h400);
      check(cur, 32'hD1);
      check(sav, STATUS_RESET);
      u_dp.wr(4'h8, SIZE_WORD, 1'b0, 32'hC8);
      for (int i = 0; i < 13; i++)
      begin
         u_dp.rd(4'(i), 4'hE, ra, rb);
         check(ra, i < 8 ? 32'hB0 + i : (i == 8 ? 32'hC8 : 32'h0));
         check(rb, 32'h400);
      end
      u_dp.ret();
      check(cur, STATUS_RESET);
      u_dp.rd(4'h8, 4'hC, ra, rb);
      check(ra, 32'hB8);
      check(rb, 32'hBC);
      $display("test fiq done");
   endtask

   // Private stack pointers; user and system share one set.
   task automatic t_stack();
      for (int k = 0; k < 6; k++)
      begin
         u_dp.mode({24'h0, 3'b110, md[k]});
         u_dp.wr(4'hD, SIZE_WORD, 1'b0, 32'h300 + k);
      end
      for (int k = 0; k < 6; k++)
      begin
         u_dp.mode({24'h0, 3'b110, md[k]});
         check({31'h0, sav_v}, k < 5 ? 32'h1 : 32'h0);
         u_dp.rd(4'hD, 4'h0, ra, rb);
         check(ra, 32'h300 + k);
      end
      u_dp.mode(32'h10);
      check({31'h0, priv}, 32'h0);
      u_dp.rd(4'hD, 4'h0, ra, rb);
      check(ra, 32'h305);
      u_dp.mode(32'hF00000D3);
      check(cur, 32'hF0000010);
      u_dp.exc(MODE_SVC, 32'h500);
      check(cur, 32'hF0000093);
      check(sav, 32'hF0000010);
      check({31'h0, priv}, 32'h1);
      u_dp.rd(4'hE, 4'hD, ra, rb);
      check(ra, 32'h500);
      check(rb, 32'h300);
      $display("test stack done");
   endtask

   // Call link and program counter, seen from two modes.
   task automatic t_call();
      u_dp.call(32'h1000);
      u_dp.wr(4'hF, SIZE_WORD, 1'b0, 32'h2004);
      check(pc, 32'h2004);
      u_dp.rd(4'hF, 4'hE, ra, rb);
      check(ra, 32'h2004);
      check(rb, 32'h1000);
      u_dp.mode(32'hD2);
      u_dp.rd(4'hF, 4'hE, ra, rb);
      check(ra, 32'h2004);
      check(rb, 32'h0);
      u_dp.mode(32'hD3);
      $display("test call done");
   endtask

   // Byte, half and word writes with both extensions.
   task automatic t_sizes();
      for (int i = 0; i < 5; i++)
      begin
         u_dp.wr(4'h2, i < 2 ? SIZE_BYTE : (i < 4 ? SIZE_HALF : SIZE_WORD), ~i[0],
                 32'h12348780);
         u_dp.rd(4'h2, 4'h2, ra, rb);
         check(ra, ev[i]);
      end
      $display("test sizes done");
   endtask

   // Illegal mode code is refused; the compact state halves the width.
   task automatic t_mode();
      u_dp.mode(32'h15);
      check({31'h0, merr}, 32'h1);
      check(cur, 32'hD3);
      u_dp.mode(32'hF3);
      check({26'h0, iw}, 32'h10);
      u_dp.mode(32'hD3);
      check({26'h0, iw}, 32'h20);
      $display("test mode done");
   endtask

   // A reset in mid-run clears the registers and reloads the reset status; entry to user and return in system are ignored.
   task automatic t_rerun();
      u_dp.wr(4'h2, SIZE_WORD, 1'b0, 32'h55);
      @(negedge core_clk_i);
      sys_rst_i = 1'b1;
      repeat (2) @(posedge core_clk_i);
      @(negedge core_clk_i);
      sys_rst_i = 1'b0;
      check(cur, STATUS_RESET);
      check(pc, 32'h0);
      check({31'h0, sav_v}, 32'h1);
      u_dp.rd(4'h2, 4'hF, ra, rb);
      check(ra, 32'h0);
      check(rb, 32'h0);
      u_dp.exc(MODE_USER, 32'h700);
      check(cur, STATUS_RESET);
      u_dp.mode(32'hDF);
      u_dp.ret();
      check(cur, 32'hDF);
      check({31'h0, sav_v}, 32'h0);
      check({31'h0, priv}, 32'h1);
      $display("test rerun done");
   endtask

   // Main sequence after six cycles of reset.
   initial
   begin
      sys_rst_i = 1'b1;
      repeat (6) @(posedge core_clk_i);
      @(negedge core_clk_i);
      sys_rst_i = 1'b0;
      t_reset();
      t_fiq();
      t_stack();
      t_call();
      t_sizes();
      t_mode();
      t_rerun();
      results();
   end

   // The whole run needs under two hundred cycles; a hang is cut short here.
   initial
   begin
      repeat (5000) @(posedge core_clk_i);
      mismatches++;
      results();
   end
endmodule
`default_nettype wire
